//--- verilog/pwc_top.sv
/*
  PWM configuration slice: time-base period, special event compare with
  direction match, pair output modes and per-pin PWM/GPIO enables, all behind
  an APB slave with a sticky interrupt status and mask.
  Assumes the time-base counter and direction come from the time base on pclk,
  and the pin enable reset strap is stable around reset release.
*/
module pwc_top (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [31:0] prdata,
	// Time base inputs
	input  wire logic [14:0] time_base_counter,
	input  wire logic        count_direction_status,
	// Configuration strap
	input  wire logic        pin_enable_reset_config,
	// Generator and GPIO data
	input  wire logic [3:0]  gen_high,
	input  wire logic [3:0]  gen_low,
	input  wire logic [3:0]  gpio_high,
	input  wire logic [3:0]  gpio_low,
	// Outputs to pins and time base
	output logic      [3:0]  pin_high,
	output logic      [3:0]  pin_low,
	output logic      [3:0]  pwm_owns_high,
	output logic      [3:0]  pwm_owns_low,
	output logic      [14:0] period_value,
	output logic             special_event_trigger,
	output logic             irq
);

	// ==========================================================
	// Registers
	logic [14:0] period_r;
	logic [14:0] compare_r;
	logic        dir_sel_r;
	logic [3:0]  mode_r;
	logic [3:0]  hen_r;
	logic [3:0]  len_r;
	logic        strap_done_r;
	logic        match_q_r;
	logic        trig_r;
	logic [0:0]  stat_r;
	logic [0:0]  mask_r;
	logic        irq_r;
	logic        pready_r;
	logic        pslverr_r;
	logic [31:0] prdata_r;

	// ==========================================================
	// APB decode
	wire logic [7:0] addr      = paddr[7:0];
	wire logic       setup     = psel & ~penable;
	wire logic       wr_en     = psel & penable & pwrite & pready_r & mapped; // Unmapped writes are dropped
	wire logic       sel_per   = (addr == pwc_pkg::OFF_PERIOD);
	wire logic       sel_cmp   = (addr == pwc_pkg::OFF_COMPARE);
	wire logic       sel_pin   = (addr == pwc_pkg::OFF_PINCFG);
	wire logic       sel_cnt   = (addr == pwc_pkg::OFF_COUNTER);
	wire logic       sel_stat  = (addr == pwc_pkg::OFF_IRQ_STAT);
	wire logic       sel_mask  = (addr == pwc_pkg::OFF_IRQ_MASK);
	wire logic       mapped    = (paddr[31:8] == 24'h000000) &
	                             (sel_per | sel_cmp | sel_pin | sel_cnt | sel_stat | sel_mask);
	wire logic       wr_per    = wr_en & sel_per;
	wire logic       wr_cmp    = wr_en & sel_cmp;
	wire logic       wr_pin    = wr_en & sel_pin;
	wire logic       wr_stat   = wr_en & sel_stat;
	wire logic       wr_mask   = wr_en & sel_mask;

	// Read views; unused upper bits stay zero
	wire logic [31:0] rd_per  = {17'h00000, period_r};
	wire logic [31:0] rd_cmp  = {16'h0000, dir_sel_r, compare_r};
	wire logic [31:0] rd_pin  = {20'h00000, mode_r, hen_r, len_r};
	wire logic [31:0] rd_cnt  = {16'h0000, count_direction_status, time_base_counter};
	wire logic [31:0] rd_stat = {31'h00000000, stat_r};
	wire logic [31:0] rd_mask = {31'h00000000, mask_r};
	wire logic [31:0] prdata_nxt =
		sel_per  ? rd_per  :
		sel_cmp  ? rd_cmp  :
		sel_pin  ? rd_pin  :
		sel_cnt  ? rd_cnt  :
		sel_stat ? rd_stat :
		sel_mask ? rd_mask : 32'h00000000;

	// Answer in the first access cycle; read data caught in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_r  <= 1'h0;
			pslverr_r <= 1'h0;
			prdata_r  <= 32'h00000000;
		end else begin
			pready_r  <= setup;
			pslverr_r <= setup & ~mapped;
			prdata_r  <= (setup & mapped) ? prdata_nxt : 32'h00000000; // Unmapped reads return zero
		end
	end

	// ==========================================================
	// Period and compare registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			period_r  <= pwc_pkg::PERIOD_RST;
			compare_r <= pwc_pkg::COMPARE_RST;
			dir_sel_r <= pwc_pkg::DIRSEL_RST;
		end else begin
			if (wr_per) begin
				period_r <= pwdata[14:0];
			end
			if (wr_cmp) begin
				compare_r <= pwdata[14:0];
				dir_sel_r <= pwdata[pwc_pkg::DIR_BIT];
			end
		end
	end

	// ==========================================================
	// Pin configuration
	// The strap is read on the first edge after release, never under reset itself
	wire logic [3:0] en_strap = pin_enable_reset_config ? pwc_pkg::EN_ALL_OFF : pwc_pkg::EN_ALL_ON;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_r       <= pwc_pkg::MODE_RST;
			hen_r        <= pwc_pkg::EN_ALL_OFF;
			len_r        <= pwc_pkg::EN_ALL_OFF;
			strap_done_r <= 1'h0;
		end else begin
			strap_done_r <= 1'h1;
			if (!strap_done_r) begin
				hen_r <= en_strap;
				len_r <= en_strap;
			end else if (wr_pin) begin
				mode_r <= pwdata[pwc_pkg::MODE_LSB +: pwc_pkg::NPAIR];
				hen_r  <= pwdata[pwc_pkg::HEN_LSB +: pwc_pkg::NPAIR];
				len_r  <= pwdata[pwc_pkg::LEN_LSB +: pwc_pkg::NPAIR];
			end
		end
	end

	// ==========================================================
	// Special event trigger
	// Edge of the match: a prescaled counter sits on one value for many clocks
	wire logic dir_match = (dir_sel_r == count_direction_status);
	wire logic val_match = (compare_r == time_base_counter);
	wire logic match     = dir_match & val_match;
	wire logic trig_nxt  = match & ~match_q_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			match_q_r <= 1'h0;
			trig_r    <= 1'h0;
		end else begin
			match_q_r <= match;
			trig_r    <= trig_nxt;
		end
	end

	// ==========================================================
	// Interrupt status and mask; a new event wins over a clear
	wire logic [0:0] stat_set = trig_nxt;
	wire logic [0:0] stat_nxt = (stat_r & ~(wr_stat ? pwdata[0:0] : 1'h0)) | stat_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 1'h0;
			mask_r <= pwc_pkg::MASK_RST;
			irq_r  <= 1'h0;
		end else begin
			stat_r <= stat_nxt;
			if (wr_mask) begin
				mask_r <= pwdata[0:0];
			end
			irq_r <= |(stat_nxt & (wr_mask ? pwdata[0:0] : mask_r));
		end
	end

	// ==========================================================
	// Output pairs
	genvar gi;
	generate
		for (gi = 0; gi < pwc_pkg::NPAIR; gi++) begin : g_pair
			pwc_pair_out u_pair (
				.pclk        (pclk),
				.presetn     (presetn),
				.high_en     (hen_r[gi]),
				.low_en      (len_r[gi]),
				.independent (mode_r[gi]),
				.gen_high    (gen_high[gi]),
				.gen_low     (gen_low[gi]),
				.gpio_high   (gpio_high[gi]),
				.gpio_low    (gpio_low[gi]),
				.pin_high_r  (pin_high[gi]),
				.pin_low_r   (pin_low[gi]),
				.own_high_r  (pwm_owns_high[gi]),
				.own_low_r   (pwm_owns_low[gi])
			);
		end
	endgenerate

	// ==========================================================
	// Output drive
	assign pready                = pready_r;
	assign pslverr               = pslverr_r;
	assign prdata                = prdata_r;
	assign period_value          = period_r;
	assign special_event_trigger = trig_r;
	assign irq                   = irq_r;

	// ==========================================================
	// Assertions
	// The trigger, low-pin GPIO and strap checks stay off until the first edge after release,
	// since the release edge itself still ran the reset branch
	wire logic asrt_live = presetn & strap_done_r;

	property p_period_write;
		@(posedge pclk) disable iff (!presetn)
		wr_per |=> period_value == $past(pwdata[14:0]);
	endproperty
	a_period_write: assert property (p_period_write) else $error("period not stored");

	property p_period_top_zero;
		@(posedge pclk) disable iff (!presetn)
		(setup && sel_per && mapped) |=> (prdata[31:15] == 17'h00000) && (prdata[14:0] == period_r);
	endproperty
	a_period_top_zero: assert property (p_period_top_zero) else $error("period read wrong");

	property p_compare_write;
		@(posedge pclk) disable iff (!presetn)
		wr_cmp |=> compare_r == $past(pwdata[14:0]) && dir_sel_r == $past(pwdata[15]);
	endproperty
	a_compare_write: assert property (p_compare_write) else $error("compare not stored");

	property p_trig_down_only;
		@(posedge pclk) disable iff (!presetn)
		(special_event_trigger && $past(dir_sel_r)) |-> $past(count_direction_status);
	endproperty
	a_trig_down_only: assert property (p_trig_down_only) else $error("trigger on wrong direction");

	property p_trig_dir_match;
		@(posedge pclk) disable iff (!presetn)
		special_event_trigger |-> $past(dir_sel_r == count_direction_status);
	endproperty
	a_trig_dir_match: assert property (p_trig_dir_match) else $error("trigger without direction match");

	property p_trig_on_match;
		@(posedge pclk) disable iff (!asrt_live)
		(compare_r == time_base_counter && dir_match && !match_q_r) |=> special_event_trigger && stat_r[0];
	endproperty
	a_trig_on_match: assert property (p_trig_on_match) else $error("missed trigger");

	property p_high_pin;
		@(posedge pclk) disable iff (!presetn)
		hen_r[0] |=> pin_high[0] == $past(gen_high[0]) && pwm_owns_high[0];
	endproperty
	a_high_pin: assert property (p_high_pin) else $error("high pin not from generator");

	property p_complementary;
		@(posedge pclk) disable iff (!presetn)
		(len_r[1] && !mode_r[1]) |=> pin_low[1] == !$past(gen_high[1]);
	endproperty
	a_complementary: assert property (p_complementary) else $error("low pin not complementary");

	property p_dir_read;
		@(posedge pclk) disable iff (!presetn)
		(setup && sel_cnt && mapped) |=> prdata[15] == $past(count_direction_status);
	endproperty
	a_dir_read: assert property (p_dir_read) else $error("direction status read wrong");

	property p_low_gpio;
		@(posedge pclk) disable iff (!asrt_live)
		!len_r[2] |=> pin_low[2] == $past(gpio_low[2]) && !pwm_owns_low[2];
	endproperty
	a_low_gpio: assert property (p_low_gpio) else $error("low pin not released");

	property p_strap_reset;
		@(posedge pclk) disable iff (!asrt_live)
		!strap_done_r |=> hen_r == $past(en_strap) && len_r == $past(en_strap);
	endproperty
	a_strap_reset: assert property (p_strap_reset) else $error("enables ignore strap");

	property p_irq_level;
		@(posedge pclk) disable iff (!presetn)
		(stat_r[0] && mask_r[0]) |-> irq;
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt not raised");

	c_trigger: cover property (@(posedge pclk) disable iff (!presetn) special_event_trigger);
	c_irq: cover property (@(posedge pclk) disable iff (!presetn) irq ##[1:20] !irq);
	c_independent: cover property (@(posedge pclk) disable iff (!presetn) mode_r[0] && len_r[0]);
	c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

//--- common/pwc_pkg.sv
/*
  Package for the PWM period, special event and pin configuration block:
  register offsets, field positions, reset values and widths.
  Assumes an APB slave with 32-bit data, one register per aligned word.
*/
package pwc_pkg;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_PERIOD   = 8'h00; // time_base_period
	localparam logic [7:0] OFF_COMPARE  = 8'h04; // special_event_compare
	localparam logic [7:0] OFF_PINCFG   = 8'h08; // output_pair_mode_and_pin_enable
	localparam logic [7:0] OFF_COUNTER  = 8'h0c; // time_base_counter view, read-only
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10; // sticky event status, write one to clear
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14; // interrupt enable mask

	// ==========================================================
	// Field layout
	localparam int VAL_W      = 15; // period and compare value width
	localparam int DIR_BIT    = 15; // direction bit in compare and counter views
	localparam int NPAIR      = 4;  // output pairs
	localparam int MODE_LSB   = 8;  // pair-mode bits [11:8]
	localparam int HEN_LSB    = 4;  // high enables [7:4]
	localparam int LEN_LSB    = 0;  // low enables [3:0]
	localparam int IRQ_W      = 1;  // one event source
	localparam int IRQ_SEV    = 0;  // special event trigger status bit

	// ==========================================================
	// Reset values
	localparam logic [14:0] PERIOD_RST  = 15'h0000;
	localparam logic [14:0] COMPARE_RST = 15'h0000;
	localparam logic        DIRSEL_RST  = 1'h0;
	localparam logic [3:0]  MODE_RST    = 4'h0;
	localparam logic [3:0]  EN_ALL_ON   = 4'hf; // enables when the strap is 0
	localparam logic [3:0]  EN_ALL_OFF  = 4'h0; // enables when the strap is 1
	localparam logic [0:0]  MASK_RST    = 1'h0;

endpackage

//--- verilog/pwc_pair_out.sv
/*
  One output pair: chooses PWM or general-purpose data for the high and low
  pins, in independent or complementary mode, and registers the result.
  Assumes generator and GPIO data are synchronous to pclk.
*/
module pwc_pair_out (
	// Clock and reset
	input  wire logic pclk,
	input  wire logic presetn,
	// Configuration
	input  wire logic high_en,
	input  wire logic low_en,
	input  wire logic independent,
	// Data sources
	input  wire logic gen_high,
	input  wire logic gen_low,
	input  wire logic gpio_high,
	input  wire logic gpio_low,
	// Pins
	output logic      pin_high_r,
	output logic      pin_low_r,
	output logic      own_high_r,
	output logic      own_low_r
);

	// ==========================================================
	// Output selection
	// Complementary mode derives low from high so both PWM-driven pins can never be on together
	wire logic pwm_low_src  = independent ? gen_low : ~gen_high;
	wire logic pin_high_nxt = high_en ? gen_high : gpio_high;
	wire logic pin_low_nxt  = low_en ? pwm_low_src : gpio_low;

	// Registered pins avoid glitches on the power stage
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_high_r <= 1'h0;
			pin_low_r  <= 1'h0;
			own_high_r <= 1'h0;
			own_low_r  <= 1'h0;
		end else begin
			pin_high_r <= pin_high_nxt;
			pin_low_r  <= pin_low_nxt;
			own_high_r <= high_en;
			own_low_r  <= low_en;
		end
	end

endmodule

//--- tb/pwc_power_stage.sv
/*
  Power stage model: half-bridge switches that follow the pins the PWM owns.
  Assumes registered pin levels and ownership flags from the block on pclk.
*/
module pwc_power_stage (
	// Pin side of the block
	input  wire logic [3:0] pin_high,
	input  wire logic [3:0] pin_low,
	input  wire logic [3:0] pwm_owns_high,
	input  wire logic [3:0] pwm_owns_low,
	// Switch states seen by the bench
	output logic      [3:0] sw_high,
	output logic      [3:0] sw_low,
	output logic            shoot
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Switches
	// A pin handed back to GPIO does not steer a switch here
	assign sw_high = pin_high & pwm_owns_high;
	assign sw_low  = pin_low & pwm_owns_low;
	// Both switches of a leg on would short the supply
	assign shoot   = |(sw_high & sw_low);
endmodule

//--- tb/tb_pwc_top.sv
/*
  Self-checking bench for pwc_top: APB register tasks, trigger and pin tests.
  Assumes the zero-wait APB slave and one-cycle registered outputs of pwc_top.
*/
module tb_pwc_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// Signals
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, dir, strap, trig, irq, shoot;
	logic [31:0] paddr, pwdata, prdata, q;
	logic [14:0] cnt, per;
	logic [3:0]  gh, gl, ph, pl, oh, ol, swh, swl;
	logic        e;
	int          fails, checks_done, cyc, trig_n;
	localparam logic [3:0] GH = 4'ha, GL = 4'h6, GPH = 4'h3, GPL = 4'h5;
	logic [11:0] cfg [4] = '{12'h0ff, 12'hfff, 12'h5a3, 12'h000};
	logic        sht [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

	pwc_top pwc_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
		.time_base_counter(cnt), .count_direction_status(dir), .pin_enable_reset_config(strap),
		.gen_high(gh), .gen_low(gl), .gpio_high(GPH), .gpio_low(GPL), .pin_high(ph), .pin_low(pl),
		.pwm_owns_high(oh), .pwm_owns_low(ol), .period_value(per), .special_event_trigger(trig), .irq(irq));
	pwc_power_stage pwc_power_stage_inst (.pin_high(ph), .pin_low(pl), .pwm_owns_high(oh),
		.pwm_owns_low(ol), .sw_high(swh), .sw_low(swl), .shoot(shoot));

	// ==========================================================
	// Clock, pulse counter and hang guard
	initial pclk = 1'b0;
	always #10 pclk = ~pclk;
	// Counting pulses avoids sampling a one-cycle strobe at an exact edge
	always @(posedge pclk) begin
		if (trig === 1'b1) trig_n <= trig_n + 1;
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			fails++;
			stop_test();
		end
	end

	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: expected %h got %h", $time, exp, got);
		end
	endtask
	// Holds the request until pready is sampled high, then releases it
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {24'h0, a};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(exp, q);
	endtask
	task automatic rst(input logic s);
		@(posedge pclk);
		presetn <= 1'b0;
		strap <= s;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (2) @(posedge pclk);
	endtask
	// Moves the time base, then lets any pulse pass
	task automatic step(input logic [14:0] c, input logic d);
		@(posedge pclk);
		cnt <= c;
		dir <= d;
		repeat (4) @(posedge pclk);
		#1;
	endtask
	function automatic logic [15:0] pins(input logic [11:0] c);
		logic [3:0] lsrc;
		lsrc = (c[11:8] & GL) | (~c[11:8] & ~GH);
		return {c[7:4], c[3:0], (c[7:4] & GH) | (~c[7:4] & GPH), (c[3:0] & lsrc) | (~c[3:0] & GPL)};
	endfunction
	task automatic stop_test();
		$display("checks_done %0d fails %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial begin
		{presetn, psel, penable, pwrite, dir, strap} = '0;
		{paddr, pwdata, fails, checks_done, cyc, trig_n} = '0;
		// Counter parked off the reset compare value so reset alone raises no trigger
		cnt = 15'h7fff;
		gh = GH;
		gl = GL;
		rst(1'b0);
		chk(0, trig_n);
		rd(8'h08, 32'h0ff);
		chk(8'hff, {oh, ol});
		rd(8'h00, 32'h0);
		apb(1'b1, 8'h00, 32'hffff_ffff);
		rd(8'h00, 32'h7fff);
		chk(32'h7fff, {17'h0, per});
		$display("test registers done");
		apb(1'b1, 8'h04, 32'h9234);
		rd(8'h04, 32'h9234);
		apb(1'b1, 8'h14, 32'h1);
		step(15'h1234, 1'b0);
		chk(0, trig_n);
		rd(8'h0c, 32'h1234);
		step(15'h1234, 1'b1);
		chk(1, trig_n);
		chk(1, irq);
		rd(8'h0c, 32'h9234);
		step(15'h1235, 1'b1);
		chk(1, trig_n);
		step(15'h1234, 1'b1);
		chk(2, trig_n);
		step(15'h0, 1'b1);
		apb(1'b1, 8'h10, 32'h1);
		rd(8'h10, 32'h0);
		chk(0, irq);
		apb(1'b1, 8'h14, 32'h0);
		apb(1'b1, 8'h04, 32'h0005);
		step(15'h0005, 1'b0);
		chk(3, trig_n);
		rd(8'h10, 32'h1);
		chk(0, irq);
		$display("test trigger done");
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, 8'h08, {20'h0, cfg[i]});
			repeat (3) @(posedge pclk);
			#1;
			chk(pins(cfg[i]), {oh, ol, ph, pl});
			chk(sht[i], shoot);
		end
		$display("test pins done");
		rd(8'h20, 32'h0);
		chk(1, e);
		rst(1'b1);
		rd(8'h08, 32'h0);
		chk(0, {oh, ol});
		rd(8'h00, 32'h0);
		$display("test unmapped and reset done");
		stop_test();
	end
endmodule
